//--- sim/ifpl_src_model.sv
// Behavioural model of the core and the peripheral request sources
`timescale 1ns/10ps
module ifpl_src_model (
    input  wire logic       clk_i,
    output logic      [5:0] ev_o,
    output logic            instr_o
);
    initial begin
        ev_o    = 6'h00;
        instr_o = 1'b0;
    end
    // One-cycle event pulse: traps in [2:0], peripheral requests in [5:3]
    task automatic fire(input logic [5:0] m);
        @(posedge clk_i);
        ev_o <= m;
        @(posedge clk_i);
        ev_o <= 6'h00;
    endtask
    // Retire n instructions, one pulse every other cycle
    task automatic retire(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            instr_o <= 1'b1;
            @(posedge clk_i);
            instr_o <= 1'b0;
        end
    endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the flag and priority block
`timescale 1ns/10ps
`include "ifpl_defines.svh"
module tb_top;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [5:0]  ev;
    logic        instr;
    logic [3:0]  src_req;
    logic [3:0]  lane;
    logic        irq_o;
    logic [3:0]  prio_req_o;
    logic        block_active_o;
    int          num_errors;
    int          n_checks;

    // Clock at 40 MHz
    always #12.5 clk_i = ~clk_i;

    ifpl_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .address_fault_i(ev[0]),
        .stack_fault_i(ev[1]), .oscillator_fault_i(ev[2]), .can_receive_ready_i(ev[3]),
        .serial_port_two_event_i(ev[4]), .serial_port_two_error_i(ev[5]),
        .prio_src_req_i(src_req), .instr_done_i(instr), .irq_o(irq_o),
        .prio_req_o(prio_req_o), .block_active_o(block_active_o));

    ifpl_src_model src (.clk_i(clk_i), .ev_o(ev), .instr_o(instr));

    // Counted comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= lane;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            $display("unexpected at %0t: no ack", $time);
            close_out();
        end else begin
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp, "read");
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask

    // Reset contents, unmapped place and unimplemented priority bits
    task automatic t_regs;
        rdc(`IFPL_OFF_TRAP, 32'h0);
        rdc(`IFPL_OFF_FLAG, 32'h0);
        rdc(`IFPL_OFF_PRIO, `IFPL_PRIO_RST);
        chk(prio_req_o, 4'h0, "idle requests");
        wr(8'h20, 32'hFFFF);
        rdc(8'h20, 32'h0);
        wr(`IFPL_OFF_PRIO, 32'hFFFF);
        rdc(`IFPL_OFF_PRIO, `IFPL_PRIO_IMPL);
        // Upper byte lane only: lower fields keep their value
        lane = 4'h2;
        wr(`IFPL_OFF_PRIO, 32'h0);
        lane = 4'hF;
        rdc(`IFPL_OFF_PRIO, 32'h0077);
    endtask

    // Each event sets its own sticky bit, then write-one clears
    task automatic t_events;
        logic [31:0] t;
        logic [31:0] f;
        t = 0;
        f = 0;
        for (int i = 0; i < 6; i++) begin
            src.fire(6'h01 << i);
            if (i < 3) t = t | (32'h8 >> i);
            else f = f | (32'h4 >> (i - 3));
            settle();
            rdc(`IFPL_OFF_TRAP, t);
            rdc(`IFPL_OFF_FLAG, f);
        end
        rdc(`IFPL_OFF_TRAP, 32'hE);
        wr(`IFPL_OFF_TRAP, 32'h8);
        rdc(`IFPL_OFF_TRAP, 32'h6);
        // Event and clear taken at one edge: the event wins
        fork
            src.fire(6'h01);
            wr(`IFPL_OFF_TRAP, 32'h8);
        join
        rdc(`IFPL_OFF_TRAP, 32'hE);
        wr(`IFPL_OFF_TRAP, 32'h8);
        rdc(`IFPL_OFF_TRAP, 32'h6);
        wr(`IFPL_OFF_FLAG, 32'h1);
        rdc(`IFPL_OFF_FLAG, 32'h6);
    endtask

    // Masked interrupt line raised and dropped
    task automatic t_irq;
        settle();
        chk(irq_o, 1'b0, "irq masked");
        wr(`IFPL_OFF_TMASK, 32'h2);
        rdc(`IFPL_OFF_TMASK, 32'h2);
        chk(irq_o, 1'b1, "irq osc");
        wr(`IFPL_OFF_TRAP, 32'h2);
        settle();
        chk(irq_o, 1'b0, "irq cleared");
        wr(`IFPL_OFF_FMASK, 32'h4);
        settle();
        chk(irq_o, 1'b1, "irq can");
        wr(`IFPL_OFF_FLAG, 32'h4);
        settle();
        chk(irq_o, 1'b0, "irq can cleared");
    endtask

    // Field positions, codes, timed block
    task automatic t_prio;
        src_req <= 4'hF;
        for (int k = 0; k < 4; k++) begin
            wr(`IFPL_OFF_PRIO, 32'h1 << (4 * k));
            settle();
            chk(prio_req_o, 4'h1 << k, "field place");
        end
        for (int c = 0; c < 8; c++) begin
            wr(`IFPL_OFF_PRIO, c * 32'h1111);
            rdc(`IFPL_OFF_PRIO, c * 32'h1111);
            chk(prio_req_o, (c != 0) ? 4'hF : 4'h0, "code");
        end
        wr(`IFPL_OFF_BLOCK, 32'h5);
        for (int c = 5; c < 8; c++) begin
            wr(`IFPL_OFF_PRIO, c * 32'h1111);
            settle();
            chk(prio_req_o, (c == 7) ? 4'hF : 4'h0, "blocked");
        end
        wr(`IFPL_OFF_PRIO, 32'h6666);
        src.retire(4);
        settle();
        chk(block_active_o, 1'b1, "block held");
        chk(prio_req_o, 4'h0, "still blocked");
        src.retire(1);
        settle();
        chk(block_active_o, 1'b0, "block over");
        chk(prio_req_o, 4'hF, "released");
        rdc(`IFPL_OFF_BLOCK, 32'h0);
    endtask

    // Main sequence
    initial begin
        clk_i      = 1'b0;
        rst_i      = 1'b1;
        wb_cyc_i   = 1'b0;
        wb_stb_i   = 1'b0;
        wb_we_i    = 1'b0;
        wb_adr_i   = 8'h00;
        wb_sel_i   = 4'h0;
        wb_dat_i   = 32'h0;
        src_req    = 4'h0;
        lane       = 4'hF;
        num_errors = 0;
        n_checks   = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_events();
        t_irq();
        t_prio();
        close_out();
    end
endmodule

//--- verilog/ifpl_defines.svh
// Offsets, field positions, reset values and widths of the flag and priority block
// How it works
// - Address error trap sets bit 3 of the trap status register; otherwise reads 0.
// - Stack error trap sets bit 2 of the trap status register; otherwise reads 0.
// - Oscillator failure trap sets bit 1 of the trap status register; otherwise 0.
// - Bit 0 of the trap status register is unimplemented and always reads 0.
// - Receive-ready request from the CAN module sets flag register bit 2.
// - Event request from the second serial port sets flag register bit 1.
// - Error request from the second serial port sets flag register bit 0.
// - Priority field 111 is level 7, 001 is level 1, 000 disables the source.
// - Capture eight priority sits at bits 14-12, capture seven at bits 10-8.
// - Converter two priority sits at bits 6-4, external one at bits 2-0.
// - Bits 15, 11, 7 and 3 of the priority register read as 0.
// - After reset every priority field holds 100, which is level 4.
// - A timed block masks requests below level 7 for the written instruction count.
`ifndef IFPL_DEFINES_SVH
`define IFPL_DEFINES_SVH

`define IFPL_ADR_W        8
`define IFPL_OFF_TRAP     8'h00
`define IFPL_OFF_FLAG     8'h04
`define IFPL_OFF_PRIO     8'h08
`define IFPL_OFF_TMASK    8'h0C
`define IFPL_OFF_FMASK    8'h10
`define IFPL_OFF_BLOCK    8'h14

`define IFPL_TRAP_ADDR    3
`define IFPL_TRAP_STACK   2
`define IFPL_TRAP_OSC     1
`define IFPL_FLAG_CAN     2
`define IFPL_FLAG_SPEV    1
`define IFPL_FLAG_SPERR   0

`define IFPL_PRIO_CAP8    14
`define IFPL_PRIO_CAP7    10
`define IFPL_PRIO_CONV2   6
`define IFPL_PRIO_EXT1    2
`define IFPL_PRIO_IMPL    16'h7777
`define IFPL_PRIO_RST     16'h4444
`define IFPL_LVL_TOP      3'h7
`define IFPL_LVL_OFF      3'h0

`define IFPL_BLOCK_W      14
`define IFPL_SRC_N        4

`endif

//--- verilog/ifpl_pkg.sv
// Types shared by the flag and priority block
package ifpl_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        IFPL_SEL_TRAP  = 3'b000,
        IFPL_SEL_FLAG  = 3'b001,
        IFPL_SEL_PRIO  = 3'b010,
        IFPL_SEL_TMASK = 3'b011,
        IFPL_SEL_FMASK = 3'b100,
        IFPL_SEL_BLOCK = 3'b101,
        IFPL_SEL_NONE  = 3'b111
    } ifpl_sel_t;

    // Whole state of the top module
    typedef struct packed {
        logic [2:0]  trap;
        logic [2:0]  flag;
        logic [15:0] prio;
        logic [2:0]  trap_mask;
        logic [2:0]  flag_mask;
        logic [13:0] block_cnt;
        logic        ack;
        logic [31:0] rdata;
        logic        irq;
        logic [3:0]  grant;
        logic        block_q;
    } ifpl_state_t;

endpackage

//--- verilog/ifpl_prio_gate.sv
// Priority decode and timed block gate for the four priority sources
`timescale 1ns/10ps
`include "ifpl_defines.svh"
module ifpl_prio_gate
    import ifpl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    ifpl_prio_if.gate pif
);

    // Field code to level: 000 off, others map straight to their binary value
    function automatic logic [2:0] ifpl_level(input logic [2:0] code);
        ifpl_level = code;
    endfunction

    // One gate per source; field i sits at bits 4*i+2 .. 4*i
    genvar gi;
    generate
        for (gi = 0; gi < `IFPL_SRC_N; gi++) begin : g_src
            logic [2:0] lvl;
            assign lvl = ifpl_level(pif.prio_fields[4*gi +: 3]);
            assign pif.grant[gi] = pif.src_req[gi]
                                 & (lvl != `IFPL_LVL_OFF)
                                 & (~pif.block_active | (lvl == `IFPL_LVL_TOP));

            disabled_src_a : assert property (@(posedge clk_i) disable iff (rst_i)
                (pif.prio_fields[4*gi +: 3] == `IFPL_LVL_OFF) |-> !pif.grant[gi])
                else $error("disabled source granted");
            block_low_a : assert property (@(posedge clk_i) disable iff (rst_i)
                (pif.block_active && pif.prio_fields[4*gi +: 3] != `IFPL_LVL_TOP)
                |-> !pif.grant[gi])
                else $error("low level request passed during block");
            pass_req_a : assert property (@(posedge clk_i) disable iff (rst_i)
                (pif.src_req[gi] && !pif.block_active
                 && pif.prio_fields[4*gi +: 3] != `IFPL_LVL_OFF) |-> pif.grant[gi])
                else $error("enabled request not passed");
        end
    endgenerate

endmodule

//--- verilog/ifpl_prio_if.sv
// Signals between the register file and the priority gate
`timescale 1ns/10ps
interface ifpl_prio_if;
    logic [15:0] prio_fields;
    logic [3:0]  src_req;
    logic        block_active;
    logic [3:0]  grant;

    modport ctrl (output prio_fields, output src_req, output block_active, input grant);
    modport gate (input prio_fields, input src_req, input block_active, output grant);
endinterface

//--- verilog/ifpl_top.sv
// Trap status, interrupt flags, priority fields and timed block behind a Wishbone slave
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`include "ifpl_defines.svh"
module ifpl_top
    import ifpl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Trap events from the core, one-cycle pulses
    input  wire logic        address_fault_i,
    input  wire logic        stack_fault_i,
    input  wire logic        oscillator_fault_i,
    // Peripheral requests, one-cycle pulses
    input  wire logic        can_receive_ready_i,
    input  wire logic        serial_port_two_event_i,
    input  wire logic        serial_port_two_error_i,
    // Level requests of the four priority sources: ext1, conv2, cap7, cap8
    input  wire logic [3:0]  prio_src_req_i,
    // Core retires one instruction
    input  wire logic        instr_done_i,
    output logic             irq_o,
    output logic      [3:0]  prio_req_o,
    output logic             block_active_o
);

    ifpl_state_t st_reg;
    ifpl_state_t st_next;
    ifpl_prio_if pif ();

    // Address to register select
    function automatic ifpl_sel_t ifpl_decode(input logic [7:0] adr);
        case (adr)
            `IFPL_OFF_TRAP:  ifpl_decode = IFPL_SEL_TRAP;
            `IFPL_OFF_FLAG:  ifpl_decode = IFPL_SEL_FLAG;
            `IFPL_OFF_PRIO:  ifpl_decode = IFPL_SEL_PRIO;
            `IFPL_OFF_TMASK: ifpl_decode = IFPL_SEL_TMASK;
            `IFPL_OFF_FMASK: ifpl_decode = IFPL_SEL_FMASK;
            `IFPL_OFF_BLOCK: ifpl_decode = IFPL_SEL_BLOCK;
            default:         ifpl_decode = IFPL_SEL_NONE;
        endcase
    endfunction

    // Merge write data into a 16-bit value under the two low byte lanes
    function automatic logic [15:0] ifpl_merge(input logic [15:0] old,
                                               input logic [15:0] wd,
                                               input logic [1:0]  sel);
        ifpl_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Bits written as one under enabled lanes
    function automatic logic [15:0] ifpl_ones(input logic [15:0] wd,
                                              input logic [1:0]  sel);
        ifpl_ones = wd & {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    logic        acc;
    logic        wr;
    ifpl_sel_t   sel;
    logic [2:0]  trap_ev;
    logic [2:0]  flag_ev;
    logic [15:0] wd16;
    logic [15:0] clr16;
    logic [15:0] tmask16;
    logic [15:0] fmask16;
    logic [15:0] blk16;

    assign acc     = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign wr      = acc & wb_we_i;
    assign sel     = ifpl_decode(wb_adr_i);
    assign wd16    = wb_dat_i[15:0];
    assign clr16   = ifpl_ones(wd16, wb_sel_i[1:0]);
    // Lane-merged write values of the mask and block count registers
    assign tmask16 = ifpl_merge({12'h000, st_reg.trap_mask, 1'b0}, wd16, wb_sel_i[1:0]);
    assign fmask16 = ifpl_merge({13'h0, st_reg.flag_mask}, wd16, wb_sel_i[1:0]);
    assign blk16   = ifpl_merge({2'h0, st_reg.block_cnt}, wd16, wb_sel_i[1:0]);
    assign trap_ev = {address_fault_i, stack_fault_i, oscillator_fault_i};
    assign flag_ev = {can_receive_ready_i, serial_port_two_event_i, serial_port_two_error_i};

    // Hand priority fields and requests to the gate
    assign pif.prio_fields  = st_reg.prio;
    assign pif.src_req      = prio_src_req_i;
    assign pif.block_active = (st_reg.block_cnt != '0);

    ifpl_prio_gate u_gate (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pif   (pif)
    );

    // Next state: sticky events, register writes, block countdown, bus answer
    always_comb begin
        st_next = st_reg;
        // Write-one-to-clear, but a same-cycle event wins
        if (wr && sel == IFPL_SEL_TRAP) begin
            st_next.trap = st_reg.trap & ~clr16[`IFPL_TRAP_ADDR:`IFPL_TRAP_OSC];
        end
        if (wr && sel == IFPL_SEL_FLAG) begin
            st_next.flag = st_reg.flag & ~clr16[`IFPL_FLAG_CAN:`IFPL_FLAG_SPERR];
        end
        st_next.trap = st_next.trap | trap_ev;
        st_next.flag = st_next.flag | flag_ev;
        // Priority fields, unimplemented bits held at zero
        if (wr && sel == IFPL_SEL_PRIO) begin
            st_next.prio = ifpl_merge(st_reg.prio, wd16, wb_sel_i[1:0])
                         & `IFPL_PRIO_IMPL;
        end
        if (wr && sel == IFPL_SEL_TMASK) begin
            st_next.trap_mask = tmask16[`IFPL_TRAP_ADDR:`IFPL_TRAP_OSC];
        end
        if (wr && sel == IFPL_SEL_FMASK) begin
            st_next.flag_mask = fmask16[`IFPL_FLAG_CAN:`IFPL_FLAG_SPERR];
        end
        // Timed block: a write loads the count, each retired instruction uses one
        if (wr && sel == IFPL_SEL_BLOCK) begin
            st_next.block_cnt = blk16[`IFPL_BLOCK_W-1:0];
        end else if (instr_done_i && st_reg.block_cnt != '0) begin
            st_next.block_cnt = st_reg.block_cnt - 14'h0001;
        end
        // Bus answer one cycle after the strobe
        st_next.ack   = acc;
        st_next.rdata = 32'h0000_0000;
        if (acc && !wb_we_i) begin
            case (sel)
                IFPL_SEL_TRAP:  st_next.rdata = {28'h0000000, st_reg.trap, 1'b0};
                IFPL_SEL_FLAG:  st_next.rdata = {29'h00000000, st_reg.flag};
                IFPL_SEL_PRIO:  st_next.rdata = {16'h0000, st_reg.prio & `IFPL_PRIO_IMPL};
                IFPL_SEL_TMASK: st_next.rdata = {28'h0000000, st_reg.trap_mask, 1'b0};
                IFPL_SEL_FMASK: st_next.rdata = {29'h00000000, st_reg.flag_mask};
                IFPL_SEL_BLOCK: st_next.rdata = {18'h00000, st_reg.block_cnt};
                default:        st_next.rdata = 32'h0000_0000;
            endcase
        end
        // Interrupt level from unmasked sticky bits
        st_next.irq     = |(st_next.trap & st_next.trap_mask)
                        | |(st_next.flag & st_next.flag_mask);
        st_next.grant   = pif.grant;
        st_next.block_q = (st_next.block_cnt != '0);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg           <= '0;
            st_reg.prio      <= `IFPL_PRIO_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o       = st_reg.rdata;
    assign wb_ack_o       = st_reg.ack;
    assign irq_o          = st_reg.irq;
    assign prio_req_o     = st_reg.grant;
    assign block_active_o = st_reg.block_q;

    // Bus request taken in this cycle
    sequence rd_s(ifpl_sel_t s);
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && sel == s;
    endsequence

    sequence wr_prio_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && sel == IFPL_SEL_PRIO
        && wb_sel_i[1:0] == 2'b11;
    endsequence

    trap_set_a : assert property (@(posedge clk_i) disable iff (rst_i)
        (trap_ev != 3'b000) |=> ((st_reg.trap & $past(trap_ev)) == $past(trap_ev)))
        else $error("trap event not recorded");

    trap_bit0_a : assert property (@(posedge clk_i) disable iff (rst_i)
        rd_s(IFPL_SEL_TRAP) |=> wb_ack_o && wb_dat_o[0] == 1'b0
        && wb_dat_o[3:1] == $past(st_reg.trap))
        else $error("trap register read wrong");

    flag_set_a : assert property (@(posedge clk_i) disable iff (rst_i)
        (flag_ev != 3'b000) |=> ((st_reg.flag & $past(flag_ev)) == $past(flag_ev)))
        else $error("flag event not recorded");

    prio_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
        wr_prio_s |=> st_reg.prio == ($past(wd16) & `IFPL_PRIO_IMPL))
        else $error("priority write not stored");

    prio_read_a : assert property (@(posedge clk_i) disable iff (rst_i)
        rd_s(IFPL_SEL_PRIO) |=> (wb_dat_o[15:0] & 16'h8888) == 16'h0000
        && wb_dat_o[15:0] == $past(st_reg.prio))
        else $error("priority read wrong");

    prio_reset_a : assert property (@(posedge clk_i)
        $past(rst_i) && !rst_i |-> st_reg.prio == `IFPL_PRIO_RST)
        else $error("priority fields not at reset pattern");

    block_count_a : assert property (@(posedge clk_i) disable iff (rst_i)
        (instr_done_i && st_reg.block_cnt != '0 && !(wr && sel == IFPL_SEL_BLOCK))
        |=> st_reg.block_cnt == $past(st_reg.block_cnt) - 14'h0001)
        else $error("block count not stepped");

    sticky_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.trap[2] && !(wr && sel == IFPL_SEL_TRAP)) |=> st_reg.trap[2])
        else $error("trap bit dropped without clear");

    ack_pulse_a : assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule
